// ==== hw/dpsr_pkg.sv ====
// Functional notes
// - One shared 18 Kb array, two interchangeable ports each reading and writing anywhere.
// - Each port has clock, enable and write strobe; all effects on clock edges. Here both ports share one clock, ref_clk_i.
// - Read registers the address and loads the stored word into the output latch.
// - Write completes on one edge, storing the input word at the address.
// - Transparent mode: written word also appears on the same port output.
// - Read-before-write mode: old word at the write address appears on output.
// - Hold-output mode: write leaves the output latch unchanged.
// - Mode chosen per port; transparent when not configured.
// - Width-mismatched conflicts invalidate only the overlapping bits.
// - Same-edge reads of one cell give identical data on both ports.
// - Same-edge writes of one cell with different data leave it undefined; the code keeps port B's word and sets STAT_DBL.
// - Write/read collision: write succeeds; read-before-write writer gives reader old data.
// - Collision with transparent or hold-output writer makes reader output undefined; the code gives the old word and sets STAT_COL_A or STAT_COL_B.
// - Setup-violating read after other port's write is invalid; write stays valid.
// - No combinational path from address to output; outputs change only on edges.
// - Output glitch-free and held until the port's next read or write.
// - Write strobe low gives read data; high gives the mode's result.
// - Port widths 1, 2, 4, 9, 18 or 36, chosen independently per port.
// - 9, 18, 36 widths carry one parity bit per byte, stored unchecked.
// - Data buses are vectors even at width one.
// - Inactive enable blocks write, read and preset, output holds.
// - Address width follows port width: 14 bits at width 1 to 9 at 36.
// - Enabled preset loads the output latch with a per-port value only; the code still stores the write when the write strobe is also high.
package dpsr_pkg;
    localparam int          DATA_BITS  = 16384;
    localparam int          PAR_BITS   = 2048;
    localparam int          MAX_WORD   = 36;
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STAT_OFS   = 12'h004;
    localparam int          MODE_A_POS = 0;
    localparam int          MODE_B_POS = 2;
    localparam logic [1:0]  MODE_RST   = 2'h0;
    localparam int          STAT_DBL   = 0;
    localparam int          STAT_COL_A = 1;
    localparam int          STAT_COL_B = 2;
    localparam logic [2:0]  STAT_RST   = 3'h0;

    typedef enum logic [1:0] {
        MODE_WRITE_FIRST = 2'h0,
        MODE_READ_FIRST  = 2'h1,
        MODE_NO_CHANGE   = 2'h2
    } dpsr_mode_t;

    function automatic int dbits(input int w);
        return (w < 9) ? w : (w / 9) * 8;
    endfunction : dbits

    function automatic int pbits(input int w);
        return (w < 9) ? 0 : w / 9;
    endfunction : pbits

    function automatic int abits(input int w);
        case (w)
            1:       return 14;
            2:       return 13;
            4:       return 12;
            9:       return 11;
            18:      return 10;
            default: return 9;
        endcase
    endfunction : abits
endpackage : dpsr_pkg

// ==== hw/dpsr_ram.sv ====
module dpsr_ram #(
    parameter int          WIDTH_A                = 36,
    parameter int          WIDTH_B                = 36,
    parameter logic [35:0] OUTPUT_PRESET_VALUE_A  = 36'h0,
    parameter logic [35:0] OUTPUT_PRESET_VALUE_B  = 36'h0
) (
    input  wire logic                                       ref_clk_i,
    input  wire logic                                       rst_b_i,
    input  wire logic                                       ce_i,
    input  wire logic                                       psel_i,
    input  wire logic                                       penable_i,
    input  wire logic                                       pwrite_i,
    input  wire logic [11:0]                                paddr_i,
    input  wire logic [31:0]                                pwdata_i,
    output logic      [31:0]                                prdata_o,
    output logic                                            pready_o,
    output logic                                            pslverr_o,
    input  wire logic                                       en_a_i,
    input  wire logic                                       we_a_i,
    input  wire logic                                       output_latch_preset_a_i,
    input  wire logic [dpsr_pkg::abits(WIDTH_A)-1:0]        addr_a_i,
    input  wire logic [dpsr_pkg::dbits(WIDTH_A)-1:0]        write_data_bus_a_i,
    input  wire logic [dpsr_pkg::pbits(WIDTH_A)/4+
                       (dpsr_pkg::pbits(WIDTH_A)>0 ?
                        dpsr_pkg::pbits(WIDTH_A)-
                        dpsr_pkg::pbits(WIDTH_A)/4 : 1)-1:0]  write_parity_bus_a_i,
    output logic      [dpsr_pkg::dbits(WIDTH_A)-1:0]        read_data_bus_a_o,
    output logic      [dpsr_pkg::pbits(WIDTH_A)/4+
                       (dpsr_pkg::pbits(WIDTH_A)>0 ?
                        dpsr_pkg::pbits(WIDTH_A)-
                        dpsr_pkg::pbits(WIDTH_A)/4 : 1)-1:0]  read_parity_bus_a_o,
    input  wire logic                                       en_b_i,
    input  wire logic                                       we_b_i,
    input  wire logic                                       output_latch_preset_b_i,
    input  wire logic [dpsr_pkg::abits(WIDTH_B)-1:0]        addr_b_i,
    input  wire logic [dpsr_pkg::dbits(WIDTH_B)-1:0]        write_data_bus_b_i,
    input  wire logic [dpsr_pkg::pbits(WIDTH_B)/4+
                       (dpsr_pkg::pbits(WIDTH_B)>0 ?
                        dpsr_pkg::pbits(WIDTH_B)-
                        dpsr_pkg::pbits(WIDTH_B)/4 : 1)-1:0]  write_parity_bus_b_i,
    output logic      [dpsr_pkg::dbits(WIDTH_B)-1:0]        read_data_bus_b_o,
    output logic      [dpsr_pkg::pbits(WIDTH_B)/4+
                       (dpsr_pkg::pbits(WIDTH_B)>0 ?
                        dpsr_pkg::pbits(WIDTH_B)-
                        dpsr_pkg::pbits(WIDTH_B)/4 : 1)-1:0]  read_parity_bus_b_o
);
    import dpsr_pkg::*;

    // Parity buses are at least one bit wide; when unused that bit reads zero, or bit DA of the preset value after a preset
    localparam int DA  = dbits(WIDTH_A);
    localparam int PA  = pbits(WIDTH_A);
    localparam int PXA = (PA > 0) ? PA : 1;
    localparam int DB  = dbits(WIDTH_B);
    localparam int PB  = pbits(WIDTH_B);
    localparam int PXB = (PB > 0) ? PB : 1;

    typedef struct packed {
        logic [DATA_BITS-1:0] mem_d;
        logic [PAR_BITS-1:0]  mem_p;
        logic [DA+PXA-1:0]    q_a;
        logic [DB+PXB-1:0]    q_b;
        logic [1:0]           mode_a;
        logic [1:0]           mode_b;
        logic [2:0]           stat;
        logic                 pready;
        logic [31:0]          prdata;
        logic                 pslverr;
    } dpsr_state_t;

    dpsr_state_t st_ff;
    dpsr_state_t nxt_st;

    logic [13:0]       didx_a;
    logic [13:0]       didx_b;
    logic [10:0]       pidx_a;
    logic [10:0]       pidx_b;
    logic [DA+PXA-1:0] rd_a;
    logic [DB+PXB-1:0] rd_b;
    logic [DA+PXA-1:0] wd_a;
    logic [DB+PXB-1:0] wd_b;
    logic              wr_a;
    logic              wr_b;
    logic              ovl;
    logic              dbl;
    logic              col_a;
    logic              col_b;
    logic              acc;

    // Output word for one port; enable gates everything, preset beats data
    function automatic logic [MAX_WORD-1:0] port_q(
        input logic [1:0]          mode,
        input logic                en,
        input logic                we,
        input logic                pre,
        input logic [MAX_WORD-1:0] q,
        input logic [MAX_WORD-1:0] rd,
        input logic [MAX_WORD-1:0] wd,
        input logic [MAX_WORD-1:0] pv
    );
        logic [MAX_WORD-1:0] r;
        r = q;
        if (!en)
        begin
            r = q;
        end
        else if (pre)
        begin
            r = pv;
        end
        else if (!we)
        begin
            r = rd;
        end
        else
        begin
            case (mode)
                MODE_READ_FIRST: r = rd;
                MODE_NO_CHANGE:  r = q;
                default:         r = wd;
            endcase
        end
        return r;
    endfunction : port_q

    always_comb
    begin
        didx_a = 14'(int'(addr_a_i) * DA);
        didx_b = 14'(int'(addr_b_i) * DB);
        // Parity index wraps harmlessly for parity-less widths; never used then
        pidx_a = 11'(int'(addr_a_i) * PXA);
        pidx_b = 11'(int'(addr_b_i) * PXB);
        rd_a = {(PA > 0) ? st_ff.mem_p[pidx_a +: PXA] : PXA'(0),
                st_ff.mem_d[didx_a +: DA]};
        rd_b = {(PB > 0) ? st_ff.mem_p[pidx_b +: PXB] : PXB'(0),
                st_ff.mem_d[didx_b +: DB]};
        wd_a = {(PA > 0) ? write_parity_bus_a_i : PXA'(0), write_data_bus_a_i};
        wd_b = {(PB > 0) ? write_parity_bus_b_i : PXB'(0), write_data_bus_b_i};
        wr_a = en_a_i && we_a_i;
        wr_b = en_b_i && we_b_i;
        // Only cells both ports actually touch count as a conflict
        ovl = (int'(didx_a) < int'(didx_b) + DB)
           && (int'(didx_b) < int'(didx_a) + DA);
        dbl = wr_a && wr_b && ovl
           && ((WIDTH_A != WIDTH_B) || (wd_a != 36'(wd_b)));
        col_a = en_a_i && !we_a_i && wr_b && ovl
             && (st_ff.mode_b != MODE_READ_FIRST);
        col_b = en_b_i && !we_b_i && wr_a && ovl
             && (st_ff.mode_a != MODE_READ_FIRST);
        acc = psel_i && penable_i;

        nxt_st = st_ff;

        // Port B lands after port A, so B owns a clashing write
        if (wr_a)
        begin
            nxt_st.mem_d[didx_a +: DA] = wd_a[DA-1:0];
            if (PA > 0)
            begin
                nxt_st.mem_p[pidx_a +: PXA] = wd_a[DA+PXA-1:DA];
            end
        end
        if (wr_b)
        begin
            nxt_st.mem_d[didx_b +: DB] = wd_b[DB-1:0];
            if (PB > 0)
            begin
                nxt_st.mem_p[pidx_b +: PXB] = wd_b[DB+PXB-1:DB];
            end
        end

        // Readers see the pre-edge array, so a read-first writer hands old data over
        nxt_st.q_a = (DA+PXA)'(port_q(st_ff.mode_a, en_a_i, we_a_i,
            output_latch_preset_a_i, 36'(st_ff.q_a), 36'(rd_a), 36'(wd_a),
            OUTPUT_PRESET_VALUE_A));
        nxt_st.q_b = (DB+PXB)'(port_q(st_ff.mode_b, en_b_i, we_b_i,
            output_latch_preset_b_i, 36'(st_ff.q_b), 36'(rd_b), 36'(wd_b),
            OUTPUT_PRESET_VALUE_B));

        // Sticky flags; a new event wins over a same-cycle clear
        if (acc && st_ff.pready && pwrite_i && paddr_i == STAT_OFS)
        begin
            nxt_st.stat = st_ff.stat & ~pwdata_i[2:0];
        end
        nxt_st.stat[STAT_DBL]   = nxt_st.stat[STAT_DBL] | dbl;
        nxt_st.stat[STAT_COL_A] = nxt_st.stat[STAT_COL_A] | col_a;
        nxt_st.stat[STAT_COL_B] = nxt_st.stat[STAT_COL_B] | col_b;

        // One wait state: answer flop rises on the second access cycle
        nxt_st.pready  = acc && !st_ff.pready;
        nxt_st.prdata  = 32'h0;
        nxt_st.pslverr = 1'b0;
        if (acc && !st_ff.pready)
        begin
            case (paddr_i)
                CTRL_OFS:
                begin
                    nxt_st.prdata = {28'h0, st_ff.mode_b, st_ff.mode_a};
                end
                STAT_OFS:
                begin
                    nxt_st.prdata = {29'h0, st_ff.stat};
                end
                default:
                begin
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end
        if (acc && st_ff.pready && pwrite_i && paddr_i == CTRL_OFS)
        begin
            nxt_st.mode_a = pwdata_i[MODE_A_POS +: 2];
            nxt_st.mode_b = pwdata_i[MODE_B_POS +: 2];
        end
    end

    // Array contents are deliberately outside the reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_ff.q_a     <= '0;
            st_ff.q_b     <= '0;
            st_ff.mode_a  <= MODE_RST;
            st_ff.mode_b  <= MODE_RST;
            st_ff.stat    <= STAT_RST;
            st_ff.pready  <= 1'b0;
            st_ff.prdata  <= 32'h0;
            st_ff.pslverr <= 1'b0;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
        end
    end

    assign read_data_bus_a_o   = st_ff.q_a[DA-1:0];
    assign read_parity_bus_a_o = st_ff.q_a[DA+PXA-1:DA];
    assign read_data_bus_b_o   = st_ff.q_b[DB-1:0];
    assign read_parity_bus_b_o = st_ff.q_b[DB+PXB-1:DB];
    assign prdata_o            = st_ff.prdata;
    assign pready_o            = st_ff.pready;
    assign pslverr_o           = st_ff.pslverr;

    AST_HOLD_A: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!ce_i || !en_a_i) |=> $stable(st_ff.q_a))
        else $error("port A output moved while disabled");

    AST_READ_A: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && en_a_i && !we_a_i && !output_latch_preset_a_i) |=> st_ff.q_a == $past(rd_a))
        else $error("port A read data wrong");

    AST_WF_A: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && wr_a && !output_latch_preset_a_i && st_ff.mode_a == MODE_WRITE_FIRST)
        |=> st_ff.q_a == $past(wd_a))
        else $error("port A transparent write wrong");

    AST_RF_B: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && wr_b && !output_latch_preset_b_i && st_ff.mode_b == MODE_READ_FIRST)
        |=> st_ff.q_b == $past(rd_b))
        else $error("port B read-before-write wrong");

    AST_NC_A: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && wr_a && !output_latch_preset_a_i && st_ff.mode_a == MODE_NO_CHANGE)
        |=> $stable(st_ff.q_a))
        else $error("port A hold-output changed");

    AST_PRESET_B: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && en_b_i && output_latch_preset_b_i)
        |=> st_ff.q_b == (DB+PXB)'(OUTPUT_PRESET_VALUE_B))
        else $error("port B preset wrong");

    AST_WRITE_A: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && wr_a && !(wr_b && ovl)) |=> st_ff.mem_d[$past(didx_a) +: DA] == $past(wd_a[DA-1:0]))
        else $error("port A write not stored");

    AST_SAME_RD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && WIDTH_A == WIDTH_B && en_a_i && en_b_i && !we_a_i && !we_b_i
         && !output_latch_preset_a_i && !output_latch_preset_b_i && ovl)
        |=> st_ff.q_a == (DA+PXA)'(st_ff.q_b))
        else $error("same-cell reads differ");

    AST_DBL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && dbl) |=> st_ff.stat[STAT_DBL] ##1 (st_ff.stat[STAT_DBL] || $past(acc)))
        else $error("double write not flagged");

    AST_APB: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && acc && !st_ff.pready) |=> st_ff.pready ##1 !st_ff.pready)
        else $error("apb answer timing wrong");
endmodule : dpsr_ram

// ==== tb/dpsr_port_user.sv ====
module dpsr_port_user #(
    parameter int AW = 9,
    parameter int DW = 36
) (
    input  wire logic          req_en_i,
    input  wire logic          req_we_i,
    input  wire logic          req_pre_i,
    input  wire logic [AW-1:0] req_addr_i,
    input  wire logic [DW-1:0] req_wd_i,
    output logic               en_o,
    output logic               we_o,
    output logic               pre_o,
    output logic      [AW-1:0] addr_o,
    output logic      [DW-1:0] wd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock for both ports, so the setup window shrinks to a shared edge
    assign en_o   = req_en_i;
    assign we_o   = req_we_i;
    assign pre_o  = req_pre_i;
    // Idle port shows inverted values so stale data is never taken for a request
    assign addr_o = req_en_i ? req_addr_i : ~req_addr_i;
    assign wd_o   = req_en_i ? req_wd_i : ~req_wd_i;
endmodule : dpsr_port_user

// ==== tb/dual_port_sync_ram_tb.sv ====
module dual_port_sync_ram_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dpsr_pkg::*;
    localparam logic [35:0] PV_A = 36'h9_3c3c_a5a5;
    localparam logic [35:0] PV_B = 36'h6_c3c3_5a5a;
    logic                  ref_clk_i = 1'b0;
    logic                  rst_b_i   = 1'b0;
    logic                  ce_i      = 1'b1;
    logic                  psel_i    = 1'b0;
    logic                  penable_i = 1'b0;
    logic                  pwrite_i  = 1'b0;
    logic [11:0]           paddr_i   = 12'h000;
    logic [31:0]           pwdata_i  = 32'h0;
    logic [31:0]           prdata_o;
    logic                  pready_o;
    logic                  pslverr_o;
    logic [1:0]            r_en = 2'h0, r_we = 2'h0, r_pre = 2'h0, pend = 2'h0;
    logic [1:0]            nx_en = 2'h0, nx_we = 2'h0, nx_pre = 2'h0;
    logic                  nx_ce = 1'b1;
    logic [1:0][8:0]       r_addr = '0, nx_addr = '0;
    logic [1:0][35:0]      r_wd = '0, nx_wd = '0;
    wire logic [1:0]       en, we, pre;
    wire logic [1:0][8:0]  addr;
    wire logic [1:0][35:0] wd, rd;
    logic [36:0]           qa[$], qb[$], ea, eb;
    logic [33:0]           qp[$], ep;
    int                    fails = 0, num_checks = 0, seed = 91709;

    always #25 ref_clk_i = ~ref_clk_i;

    dpsr_port_user #(.AW(9), .DW(36)) u_usr_a (.req_en_i(r_en[0]), .req_we_i(r_we[0]), .req_pre_i(r_pre[0]),
        .req_addr_i(r_addr[0]), .req_wd_i(r_wd[0]), .en_o(en[0]), .we_o(we[0]), .pre_o(pre[0]),
        .addr_o(addr[0]), .wd_o(wd[0]));
    dpsr_port_user #(.AW(9), .DW(36)) u_usr_b (.req_en_i(r_en[1]), .req_we_i(r_we[1]), .req_pre_i(r_pre[1]),
        .req_addr_i(r_addr[1]), .req_wd_i(r_wd[1]), .en_o(en[1]), .we_o(we[1]), .pre_o(pre[1]),
        .addr_o(addr[1]), .wd_o(wd[1]));

    // Both ports at 36 bits: 9 address bits, 32 data plus 4 parity
    dpsr_ram #(.WIDTH_A(36), .WIDTH_B(36), .OUTPUT_PRESET_VALUE_A(PV_A), .OUTPUT_PRESET_VALUE_B(PV_B)) uut (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .en_a_i(en[0]), .we_a_i(we[0]), .output_latch_preset_a_i(pre[0]), .addr_a_i(addr[0]),
        .write_data_bus_a_i(wd[0][31:0]), .write_parity_bus_a_i(wd[0][35:32]),
        .read_data_bus_a_o(rd[0][31:0]), .read_parity_bus_a_o(rd[0][35:32]),
        .en_b_i(en[1]), .we_b_i(we[1]), .output_latch_preset_b_i(pre[1]), .addr_b_i(addr[1]),
        .write_data_bus_b_i(wd[1][31:0]), .write_parity_bus_b_i(wd[1][35:32]),
        .read_data_bus_b_o(rd[1][31:0]), .read_parity_bus_b_o(rd[1][35:32]));

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    function automatic logic [35:0] rnd();
        logic [63:0] t;
        t = {$random(seed), $random(seed)};
        return t[35:0];
    endfunction : rnd

    function automatic logic [8:0] ad(input int k);
        return 9'h1fc + 9'(k);
    endfunction : ad

    // Queue one port request for the next step; expectation kept only if the port acts
    task automatic op(input int p, input logic e, w, s, input logic [8:0] a, input logic [35:0] d,
                      input logic c, input logic [35:0] x);
        nx_en[p]   = e;
        nx_we[p]   = w;
        nx_pre[p]  = s;
        nx_addr[p] = a;
        nx_wd[p]   = d;
        if (e && nx_ce && p == 0) qa.push_back({c, x});
        if (e && nx_ce && p == 1) qb.push_back({c, x});
    endtask : op

    task automatic step;
        r_en   <= nx_en;
        r_we   <= nx_we;
        r_pre  <= nx_pre;
        r_addr <= nx_addr;
        r_wd   <= nx_wd;
        ce_i   <= nx_ce;
        nx_en  = 2'h0;
        nx_we  = 2'h0;
        nx_pre = 2'h0;
        nx_ce  = 1'b1;
        @(posedge ref_clk_i);
    endtask : step

    // x = {slave error, compare data, data}
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
        int n;
        step;
        qp.push_back(x);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        // Hold the request until pready is sampled high at a rising edge
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20)
        begin
            fails++;
            tally_and_finish;
        end
    endtask : apb

    always @(posedge ref_clk_i)
        pend <= en & {2{ce_i}};

    always @(negedge ref_clk_i)
    begin
        if (pend[0])
        begin
            ea = qa.pop_front();
            if (ea[36]) check(rd[0], ea[35:0]);
        end
        if (pend[1])
        begin
            eb = qb.pop_front();
            if (eb[36]) check(rd[1], eb[35:0]);
        end
        if (pready_o === 1'b1)
        begin
            ep = qp.pop_front();
            check({3'h0, pslverr_o, ep[32] ? prdata_o : 32'h0}, {3'h0, ep[33], ep[32] ? ep[31:0] : 32'h0});
        end
    end

    initial
    begin
        #(5000 * 50);
        fails++;
        tally_and_finish;
    end

    initial
    begin
        logic [35:0] v[4];
        logic [35:0] nw;
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0, {2'b01, 32'h0});
        apb(1'b0, STAT_OFS, 32'h0, {2'b01, 32'h0});
        apb(1'b0, 12'h008, 32'h0, {2'b11, 32'h0});
        apb(1'b1, 12'h00c, 32'hffff_ffff, {2'b10, 32'h0});
        // Back-to-back writes up to the top address
        for (int k = 0; k < 4; k++)
        begin
            v[k] = rnd();
            op(1, 1'b1, 1'b1, 1'b0, ad(k), v[k], 1'b1, v[k]);
            step;
        end
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, CTRL_OFS, 32'(m), {2'b00, 32'h0});
            apb(1'b0, CTRL_OFS, 32'h0, {2'b01, 32'(m)});
            nw = rnd();
            op(0, 1'b1, 1'b0, 1'b0, ad(m + 1), rnd(), 1'b1, v[m + 1]);
            step;
            op(0, 1'b1, 1'b1, 1'b0, ad(m), nw, 1'b1, m == 0 ? nw : (m == 1 ? v[m] : v[m + 1]));
            step;
            op(1, 1'b1, 1'b0, 1'b0, ad(m), rnd(), 1'b1, nw);
            step;
            v[m] = nw;
        end
        apb(1'b1, CTRL_OFS, 32'h1, {2'b00, 32'h0});
        nw = rnd();
        op(0, 1'b1, 1'b1, 1'b0, ad(0), nw, 1'b1, v[0]);
        op(1, 1'b1, 1'b0, 1'b0, ad(0), rnd(), 1'b1, v[0]);
        step;
        op(1, 1'b1, 1'b0, 1'b0, ad(0), rnd(), 1'b1, nw);
        step;
        v[0] = nw;
        apb(1'b1, CTRL_OFS, 32'h0, {2'b00, 32'h0});
        nw = rnd();
        op(0, 1'b1, 1'b1, 1'b0, ad(1), nw, 1'b1, nw);
        op(1, 1'b1, 1'b0, 1'b0, ad(1), rnd(), 1'b0, 36'h0);
        step;
        apb(1'b0, STAT_OFS, 32'h0, {2'b01, 32'h4});
        apb(1'b1, STAT_OFS, 32'h7, {2'b00, 32'h0});
        apb(1'b0, STAT_OFS, 32'h0, {2'b01, 32'h0});
        nw = rnd();
        op(0, 1'b1, 1'b1, 1'b0, ad(2), nw, 1'b1, nw);
        op(1, 1'b1, 1'b1, 1'b0, ad(2), nw, 1'b1, nw);
        step;
        op(0, 1'b1, 1'b0, 1'b0, ad(2), rnd(), 1'b1, nw);
        op(1, 1'b1, 1'b0, 1'b0, ad(2), rnd(), 1'b1, nw);
        step;
        apb(1'b0, STAT_OFS, 32'h0, {2'b01, 32'h0});
        op(0, 1'b1, 1'b1, 1'b0, ad(2), rnd(), 1'b0, 36'h0);
        op(1, 1'b1, 1'b1, 1'b0, ad(2), rnd(), 1'b0, 36'h0);
        step;
        apb(1'b0, STAT_OFS, 32'h0, {2'b01, 32'h1});
        nw = rnd();
        op(0, 1'b1, 1'b1, 1'b1, ad(3), nw, 1'b1, PV_A);
        op(1, 1'b1, 1'b0, 1'b1, ad(3), rnd(), 1'b1, PV_B);
        step;
        op(0, 1'b1, 1'b0, 1'b0, ad(3), rnd(), 1'b1, nw);
        step;
        op(0, 1'b0, 1'b1, 1'b1, ad(3), rnd(), 1'b0, 36'h0);
        step;
        op(0, 1'b1, 1'b0, 1'b0, ad(3), rnd(), 1'b1, nw);
        step;
        // Clock enable low: the write below must leave the cell alone
        nx_ce = 1'b0;
        op(0, 1'b1, 1'b1, 1'b0, ad(0), rnd(), 1'b0, 36'h0);
        step;
        op(0, 1'b1, 1'b0, 1'b0, ad(0), rnd(), 1'b1, v[0]);
        step;
        step;
        repeat (2) @(posedge ref_clk_i);
        tally_and_finish;
    end
endmodule : dual_port_sync_ram_tb
